// ==== core/pmisf_flags.sv ====
// Purpose: system and charger sub-level interrupt flags, system mask,
//          group pending bits and the open-drain interrupt pin
// Assumes: register port strobes on the system clock; analog levels async
// Notes:   flags clear on write of one; a set in the same cycle wins
`timescale 1ns/1ps
module pmisf_flags #(
    parameter int P_ON_PUSH_CYCLES = pmisf_pkg::ON_PUSH_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_wdata,
    output logic      [7:0] o_reg_rdata,
    input  wire logic       i_on_key_n,
    input  wire logic       i_heat_warn_cmp,
    input  wire logic       i_overheat_cmp,
    input  wire logic       i_supply_low_cmp,
    input  wire logic       i_input_power_good,
    input  wire logic       i_input_current_limit,
    input  wire logic       i_battery_present_status,
    input  wire logic       i_battery_voltage_good,
    input  wire logic       i_charger_good,
    input  wire logic       i_watchdog_expiry,
    input  wire logic       i_dead_battery_timeout,
    input  wire logic       i_fast_charge_timeout,
    input  wire logic       i_precharge_timeout,
    input  wire logic [7:0] i_charger_event_mask,
    input  wire logic       i_buck_group_pending,
    input  wire logic       i_ldo_group_pending,
    input  wire logic [1:0] i_heat_warn_threshold,
    input  wire logic [2:0] i_heat_shutdown_threshold,
    input  wire logic [1:0] i_supply_low_threshold,
    output logic      [1:0] o_heat_warn_threshold,
    output logic      [2:0] o_heat_shutdown_threshold,
    output logic      [1:0] o_supply_low_threshold,
    output logic            o_system_group_pending,
    output logic            o_charger_group_pending,
    input  wire logic       i_irq_out_n,
    output logic            o_irq_out_n,
    output logic            o_irq_out_n_oe_n
);
    import pmisf_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // set has priority over a clear arriving in the same cycle
    function automatic logic [7:0] f_w1c(input logic [7:0] flags,
                                         input logic [7:0] set,
                                         input logic [7:0] clr);
        f_w1c = (flags & ~clr) | set;
    endfunction

    function automatic logic f_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        f_hit = (addr == reg_addr);
    endfunction

    // ----------------------------------------------------------------
    // pin synchronisers and glitch filter
    // ----------------------------------------------------------------
    logic [N_SYNC-1:0] raw;
    logic [N_SYNC-1:0] filt_q;
    logic [N_SYNC-1:0] filt_d;

    assign raw = {i_charger_good, i_battery_voltage_good, i_battery_present_status,
                  i_input_current_limit, i_input_power_good, i_supply_low_cmp,
                  i_overheat_cmp, i_heat_warn_cmp, i_on_key_n};

    genvar g;
    generate
        for (g = 0; g < N_SYNC; g++) begin : g_sync
            logic [2:0] sh_q;
            logic [2:0] sh_d;
            // a change counts only once the second and third stages agree
            always_comb begin
                sh_d      = {sh_q[1:0], raw[g]};
                filt_d[g] = (sh_q[1] == sh_q[2]) ? sh_q[2] : filt_q[g];
            end
            always_ff @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sh_q      <= {3{SYNC_RST[g]}};
                    filt_q[g] <= SYNC_RST[g];
                end else begin
                    sh_q      <= sh_d;
                    filt_q[g] <= filt_d[g];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // arming after reset
    // ----------------------------------------------------------------
    // filtered levels start from a guess; no level or key events until the real levels settle
    logic [2:0] arm_cnt_q;
    logic [2:0] arm_cnt_d;
    logic       armed;

    always_comb begin
        arm_cnt_d = (arm_cnt_q == ARM_CYCLES) ? arm_cnt_q : arm_cnt_q + 3'h1;
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            arm_cnt_q <= 3'h0;
        end else begin
            arm_cnt_q <= arm_cnt_d;
        end
    end

    assign armed = (arm_cnt_q == ARM_CYCLES);

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    logic [N_SYNC-1:0] rise;
    logic [N_SYNC-1:0] toggle;
    logic              press_event;

    assign rise   = {N_SYNC{armed}} & filt_d & ~filt_q;
    assign toggle = {N_SYNC{armed}} & (filt_d ^ filt_q);

    pmisf_long_press #(
        .P_CYCLES      (P_ON_PUSH_CYCLES)
    ) u_long_press (
        .i_clk         (i_clk),
        .i_rstn        (i_rstn),
        .i_key_low     (armed & ~filt_q[IDX_ON_KEY_N]),
        .o_press_event (press_event)
    );

    // ----------------------------------------------------------------
    // flag, mask and pending registers
    // ----------------------------------------------------------------
    logic [7:0] sys_flags_q;
    logic [7:0] sys_flags_d;
    logic [7:0] sys_mask_q;
    logic [7:0] sys_mask_d;
    logic [7:0] charger_flags_q;
    logic [7:0] charger_flags_d;
    logic [7:0] sys_set;
    logic [7:0] charger_set;
    logic [7:0] sys_clr;
    logic [7:0] charger_clr;
    logic       sys_pending_d;
    logic       charger_pending_d;
    logic       irq_oe_n_d;

    always_comb begin
        sys_set                            = 8'h00;
        sys_set[SYS_BIT_ON_KEY_PUSH]       = press_event;
        sys_set[SYS_BIT_DIE_HEAT_WARN]     = rise[IDX_HEAT_WARN];
        sys_set[SYS_BIT_OVERHEAT_SHUTDOWN] = rise[IDX_OVERHEAT];
        sys_set[SYS_BIT_SUPPLY_LOW_WARN]   = rise[IDX_SUPPLY_LOW];
        sys_set[SYS_BIT_WATCHDOG_EXPIRY]   = i_watchdog_expiry;
        sys_set[SYS_BIT_INPUT_POWER]       = toggle[IDX_INPUT_POWER];

        charger_set                            = 8'h00;
        charger_set[CHG_BIT_DEAD_BATTERY]      = i_dead_battery_timeout;
        charger_set[CHG_BIT_CURRENT_LIMIT]     = rise[IDX_CURRENT_LIM];
        charger_set[CHG_BIT_FAST_TIMEOUT]      = i_fast_charge_timeout;
        charger_set[CHG_BIT_PRECHARGE_TIMEOUT] = i_precharge_timeout;
        charger_set[CHG_BIT_BATTERY_PRESENT]   = toggle[IDX_BATT_PRESENT];
        charger_set[CHG_BIT_BATTERY_VOLTAGE]   = toggle[IDX_BATT_VOLTAGE];
        charger_set[CHG_BIT_CHARGER_GOOD]      = toggle[IDX_CHARGER_GOOD];

        // write one clears, write zero keeps
        sys_clr     = (i_reg_wr && f_hit(i_reg_addr, ADDR_SYS_FLAGS)) ? i_reg_wdata : 8'h00;
        charger_clr = (i_reg_wr && f_hit(i_reg_addr, ADDR_CHARGER_FLAGS)) ?
                      i_reg_wdata : 8'h00;

        // latched flags ignore repeats
        sys_flags_d     = f_w1c(sys_flags_q, sys_set, sys_clr) & SYS_FLAG_BITS;
        charger_flags_d = f_w1c(charger_flags_q, charger_set, charger_clr) & CHARGER_FLAG_BITS;

        sys_mask_d = (i_reg_wr && f_hit(i_reg_addr, ADDR_SYS_MASK)) ?
                     i_reg_wdata : sys_mask_q;

        // group bits follow the unmasked flags
        sys_pending_d     = |(sys_flags_d & ~sys_mask_d & SYS_FLAG_BITS);
        charger_pending_d = |(charger_flags_d & ~i_charger_event_mask & CHARGER_FLAG_BITS);

        // pin pulled low from the first unmasked event until all clear
        irq_oe_n_d = ~(sys_pending_d | charger_pending_d |
                       i_buck_group_pending | i_ldo_group_pending);
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sys_flags_q             <= RST_FLAGS;
            charger_flags_q         <= RST_FLAGS;
            sys_mask_q              <= RST_SYS_MASK;
            o_system_group_pending  <= 1'b0;
            o_charger_group_pending <= 1'b0;
            o_irq_out_n_oe_n        <= 1'b1;
            o_irq_out_n             <= 1'b0;
        end else begin
            sys_flags_q             <= sys_flags_d;
            charger_flags_q         <= charger_flags_d;
            sys_mask_q              <= sys_mask_d;
            o_system_group_pending  <= sys_pending_d;
            o_charger_group_pending <= charger_pending_d;
            o_irq_out_n_oe_n        <= irq_oe_n_d;
            o_irq_out_n             <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // read port and threshold selects
    // ----------------------------------------------------------------
    logic [7:0] rdata_d;
    logic [7:0] top_value;

    always_comb begin
        top_value                  = 8'h00;
        top_value[TOP_BIT_SYSTEM]  = o_system_group_pending;
        top_value[TOP_BIT_CHARGER] = o_charger_group_pending;
        top_value[TOP_BIT_BUCK]    = i_buck_group_pending;
        top_value[TOP_BIT_LDO]     = i_ldo_group_pending;
        rdata_d = o_reg_rdata;
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_TOP_PENDING:   rdata_d = top_value;
                ADDR_SYS_FLAGS:     rdata_d = sys_flags_q;
                ADDR_SYS_MASK:      rdata_d = sys_mask_q;
                ADDR_CHARGER_FLAGS: rdata_d = charger_flags_q;
                default:            rdata_d = 8'h00;
            endcase
        end
    end

    // thresholds are retimed only; the comparators live in the analog part
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata               <= RST_RDATA;
            o_heat_warn_threshold     <= 2'h0;
            o_heat_shutdown_threshold <= 3'h0;
            o_supply_low_threshold    <= 2'h0;
        end else begin
            o_reg_rdata               <= rdata_d;
            o_heat_warn_threshold     <= i_heat_warn_threshold;
            o_heat_shutdown_threshold <= i_heat_shutdown_threshold;
            o_supply_low_threshold    <= i_supply_low_threshold;
        end
    end

endmodule

// ==== common/pmisf_pkg.sv ====
// Purpose: constants and types shared by the sub-level interrupt flag logic
// Assumes: 20 MHz system clock, 8-bit register port
// Notes:   offsets and bit positions of the system and charger flag groups
package pmisf_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_TOP_PENDING  = 8'h01;
    localparam logic [7:0] ADDR_SYS_FLAGS    = 8'h02;
    localparam logic [7:0] ADDR_SYS_MASK     = 8'h03;
    localparam logic [7:0] ADDR_CHARGER_FLAGS = 8'h04;

    // ----------------------------------------------------------------
    // reset values and implemented bits
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_FLAGS         = 8'h00;
    localparam logic [7:0] RST_SYS_MASK      = 8'h3F;
    localparam logic [7:0] RST_RDATA         = 8'h00;
    localparam logic [7:0] SYS_FLAG_BITS     = 8'h3F;
    localparam logic [7:0] CHARGER_FLAG_BITS = 8'h7F;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SYS_BIT_ON_KEY_PUSH      = 5;
    localparam int SYS_BIT_DIE_HEAT_WARN    = 4;
    localparam int SYS_BIT_OVERHEAT_SHUTDOWN = 3;
    localparam int SYS_BIT_SUPPLY_LOW_WARN  = 2;
    localparam int SYS_BIT_WATCHDOG_EXPIRY  = 1;
    localparam int SYS_BIT_INPUT_POWER      = 0;
    localparam int CHG_BIT_DEAD_BATTERY     = 6;
    localparam int CHG_BIT_CURRENT_LIMIT    = 5;
    localparam int CHG_BIT_FAST_TIMEOUT     = 4;
    localparam int CHG_BIT_PRECHARGE_TIMEOUT = 3;
    localparam int CHG_BIT_BATTERY_PRESENT  = 2;
    localparam int CHG_BIT_BATTERY_VOLTAGE  = 1;
    localparam int CHG_BIT_CHARGER_GOOD     = 0;
    localparam int TOP_BIT_SYSTEM           = 3;
    localparam int TOP_BIT_CHARGER          = 2;
    localparam int TOP_BIT_BUCK             = 1;
    localparam int TOP_BIT_LDO              = 0;

    // ----------------------------------------------------------------
    // synchronised pin inputs
    // ----------------------------------------------------------------
    localparam int             N_SYNC           = 9;
    localparam int             IDX_ON_KEY_N     = 0;
    localparam int             IDX_HEAT_WARN    = 1;
    localparam int             IDX_OVERHEAT     = 2;
    localparam int             IDX_SUPPLY_LOW   = 3;
    localparam int             IDX_INPUT_POWER  = 4;
    localparam int             IDX_CURRENT_LIM  = 5;
    localparam int             IDX_BATT_PRESENT = 6;
    localparam int             IDX_BATT_VOLTAGE = 7;
    localparam int             IDX_CHARGER_GOOD = 8;
    localparam logic [8:0]     SYNC_RST         = 9'h001;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int             CLK_HZ           = 20_000_000;
    localparam int             ON_PUSH_TIME_MS  = 5;
    localparam int             ON_PUSH_CYCLES   = (ON_PUSH_TIME_MS * CLK_HZ) / 1000;
    localparam int             LP_CNT_W         = 17;
    localparam logic [2:0]     ARM_CYCLES       = 3'h4;

    typedef enum logic [2:0] {
        LP_IDLE   = 3'b001,
        LP_TIMING = 3'b010,
        LP_HELD   = 3'b100
    } pmisf_lp_state_t;

endpackage

// ==== core/pmisf_long_press.sv ====
// Purpose: detects the on-key held low longer than the push time
// Assumes: key level already synchronised and filtered
// Notes:   one event per press; a new falling edge is needed to fire again
`timescale 1ns/1ps
module pmisf_long_press #(
    parameter int P_CYCLES = pmisf_pkg::ON_PUSH_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_key_low,
    output logic      o_press_event
);
    import pmisf_pkg::*;

    localparam logic [LP_CNT_W-1:0] LIMIT = P_CYCLES[LP_CNT_W-1:0];

    pmisf_lp_state_t       state_q;
    pmisf_lp_state_t       state_d;
    logic [LP_CNT_W-1:0]   cnt_q;
    logic [LP_CNT_W-1:0]   cnt_d;
    logic                  event_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        event_d = 1'b0;
        case (state_q)
            LP_IDLE: begin
                cnt_d = '0;
                if (i_key_low) begin
                    state_d = LP_TIMING;
                end
            end
            LP_TIMING: begin
                if (!i_key_low) begin
                    state_d = LP_IDLE;
                end else if (cnt_q == LIMIT) begin
                    // strictly longer than the push time
                    event_d = 1'b1;
                    state_d = LP_HELD;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            LP_HELD: begin
                if (!i_key_low) begin
                    state_d = LP_IDLE;
                end
            end
            default: begin
                state_d = LP_HELD;
            end
        endcase
    end

    // starts in held, but i_key_low stays low until armed, so held falls to idle and a key low at reset is timed as a press once armed
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_q       <= LP_HELD;
            cnt_q         <= '0;
            o_press_event <= 1'b0;
        end else begin
            state_q       <= state_d;
            cnt_q         <= cnt_d;
            o_press_event <= event_d;
        end
    end

endmodule

// ==== tb/pmisf_host_model.sv ====
// Purpose: host side of the register port, one strobe per access
// Assumes: strobes sampled on the rising edge of i_clk
// Notes:   read data taken one edge after the strobe edge
`timescale 1ns/1ps
// ----------------------------------------
// host model
// ----------------------------------------
module pmisf_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_reg_rdata,
    output logic      [7:0] o_reg_addr,
    output logic            o_reg_wr,
    output logic            o_reg_rd,
    output logic      [7:0] o_reg_wdata
);
    initial begin
        o_reg_addr  = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr    = 1'b0;
        o_reg_rd    = 1'b0;
    end
    // released lines scrambled so a stale value never reads as intent
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_reg_addr  = a;
        o_reg_wdata = d;
        o_reg_wr    = 1'b1;
        @(posedge i_clk);
        #1;
        o_reg_wr    = 1'b0;
        o_reg_addr  = ~a;
        o_reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        #1;
        o_reg_addr = a;
        o_reg_rd   = 1'b1;
        @(posedge i_clk);
        #1;
        d          = i_reg_rdata;
        o_reg_rd   = 1'b0;
        o_reg_addr = ~a;
    endtask
endmodule

// ==== tb/pmisf_flags_sva.sv ====
// Purpose: port assertions for the sub-level flag block
// Assumes: buck and ldo pending inputs held low
// Notes:   pending bits are registered, so causes are one cycle back
`timescale 1ns/1ps
// ----------------------------------------
// checker
// ----------------------------------------
module pmisf_flags_sva
    import pmisf_pkg::*;
#(
    parameter int P_ON_PUSH_CYCLES = ON_PUSH_CYCLES
) (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic [7:0] i_reg_addr,
    input wire logic       i_reg_wr,
    input wire logic       i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic       i_dead_battery_timeout,
    input wire logic       i_fast_charge_timeout,
    input wire logic       i_precharge_timeout,
    input wire logic [7:0] i_charger_event_mask,
    input wire logic       o_system_group_pending,
    input wire logic       o_charger_group_pending,
    input wire logic       o_irq_out_n,
    input wire logic       o_irq_out_n_oe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire logic any_grp = o_system_group_pending || o_charger_group_pending;

    property p_pin_zero; o_irq_out_n == 1'b0; endproperty
    a_pin_zero: assert property (p_pin_zero)
        else $error("irq drive value not low");
    property p_irq_on; any_grp |-> !o_irq_out_n_oe_n; endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("group pending but pin released");
    property p_irq_off; !any_grp |-> o_irq_out_n_oe_n; endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("pin low with no group pending");
    property p_top_read;
        i_reg_rd && i_reg_addr == ADDR_TOP_PENDING |=> o_reg_rdata ==
            {4'h0, $past(o_system_group_pending), $past(o_charger_group_pending), 2'h0};
    endproperty
    a_top_read: assert property (p_top_read)
        else $error("top register read mismatch");
    property p_dead;
        i_dead_battery_timeout && !i_charger_event_mask[6] |=> o_charger_group_pending;
    endproperty
    a_dead: assert property (p_dead)
        else $error("dead battery event missed");
    property p_fast;
        i_fast_charge_timeout && !i_charger_event_mask[4] |=> o_charger_group_pending;
    endproperty
    a_fast: assert property (p_fast)
        else $error("fast charge event missed");
    property p_preq;
        i_precharge_timeout && !i_charger_event_mask[3] |=> o_charger_group_pending;
    endproperty
    a_preq: assert property (p_preq)
        else $error("precharge event missed");
    property p_sys_fall;
        $fell(o_system_group_pending) |-> $past(i_reg_wr) &&
            ($past(i_reg_addr) == ADDR_SYS_FLAGS || $past(i_reg_addr) == ADDR_SYS_MASK);
    endproperty
    a_sys_fall: assert property (p_sys_fall)
        else $error("system group dropped without a write");
    property p_chg_masked;
        $past(i_charger_event_mask[6:0]) == 7'h7F |-> !$rose(o_charger_group_pending);
    endproperty
    a_chg_masked: assert property (p_chg_masked)
        else $error("charger group rose while all masked");

    c_sys: cover property ($rose(o_system_group_pending));
    c_chg: cover property ($rose(o_charger_group_pending));
    c_both: cover property (o_system_group_pending && o_charger_group_pending);
endmodule

bind pmisf_flags pmisf_flags_sva #(.P_ON_PUSH_CYCLES(P_ON_PUSH_CYCLES)) u_sva (
    .i_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_dead_battery_timeout, .i_fast_charge_timeout, .i_precharge_timeout,
    .i_charger_event_mask, .o_system_group_pending, .o_charger_group_pending,
    .o_irq_out_n, .o_irq_out_n_oe_n
);

// ==== tb/testbench.sv ====
// Purpose: self-checking bench for the sub-level flag block
// Assumes: host model drives the register strobes
// Notes:   push time shortened to 20 cycles
`timescale 1ns/1ps
// ----------------------------------------
// bench
// ----------------------------------------
module testbench;
    import pmisf_pkg::*;
    localparam int PUSH = 20;
    logic       i_clk = 1'b0;
    logic       i_rstn = 1'b0;
    logic       i_on_key_n = 1'b1;
    logic [7:0] lv = 8'h00;
    logic [3:0] pul = 4'h0;
    logic [7:0] cmask = 8'h00;
    logic [6:0] thr = 7'h00;
    logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
    logic       i_reg_wr, i_reg_rd, o_irq_out_n, o_irq_out_n_oe_n;
    logic [1:0] o_heat_warn_threshold, o_supply_low_threshold;
    logic [2:0] o_heat_shutdown_threshold;
    logic       o_system_group_pending, o_charger_group_pending;
    int         err_total = 0;
    int         check_count = 0;
    int         cyc = 0;
    // open-drain pin with pull-up
    wire logic  pin_lvl = o_irq_out_n_oe_n ? 1'b1 : o_irq_out_n;
    always #25 i_clk = ~i_clk;

    pmisf_flags #(.P_ON_PUSH_CYCLES(PUSH)) u_dut (
        .i_clk, .i_rstn, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
        .i_on_key_n, .i_heat_warn_cmp(lv[0]), .i_overheat_cmp(lv[1]),
        .i_supply_low_cmp(lv[2]), .i_input_power_good(lv[3]),
        .i_input_current_limit(lv[4]), .i_battery_present_status(lv[5]),
        .i_battery_voltage_good(lv[6]), .i_charger_good(lv[7]),
        .i_watchdog_expiry(pul[0]), .i_dead_battery_timeout(pul[1]),
        .i_fast_charge_timeout(pul[2]), .i_precharge_timeout(pul[3]),
        .i_charger_event_mask(cmask), .i_buck_group_pending(1'b0),
        .i_ldo_group_pending(1'b0), .i_heat_warn_threshold(thr[1:0]),
        .i_heat_shutdown_threshold(thr[4:2]), .i_supply_low_threshold(thr[6:5]),
        .o_heat_warn_threshold, .o_heat_shutdown_threshold, .o_supply_low_threshold,
        .o_system_group_pending, .o_charger_group_pending,
        .i_irq_out_n(pin_lvl), .o_irq_out_n, .o_irq_out_n_oe_n
    );
    pmisf_host_model u_host (
        .i_clk, .i_reg_rdata(o_reg_rdata), .o_reg_addr(i_reg_addr),
        .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd), .o_reg_wdata(i_reg_wdata)
    );

    task automatic summarize();
        if (err_total == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask
    task automatic pulse(input int k);
        @(posedge i_clk);
        #1 pul[k] = 1'b1;
        @(posedge i_clk);
        #1 pul[k] = 1'b0;
    endtask
    task automatic do_reset();
        @(posedge i_clk);
        #1 i_rstn = 1'b0;
        repeat (2) @(posedge i_clk);
        #1 i_rstn = 1'b1;
        repeat (8) @(posedge i_clk);
    endtask
    task automatic t_reset_vals();
        rdc(ADDR_TOP_PENDING, 8'h00);
        rdc(ADDR_SYS_FLAGS, 8'h00);
        rdc(ADDR_SYS_MASK, 8'h3F);
        rdc(ADDR_CHARGER_FLAGS, 8'h00);
        rdc(8'h10, 8'h00);
        chk({7'h0, pin_lvl}, 8'h01);
    endtask
    task automatic t_mask();
        u_host.wr(ADDR_SYS_MASK, 8'hFF);
        rdc(ADDR_SYS_MASK, 8'hFF);
        u_host.wr(ADDR_TOP_PENDING, 8'hFF);
        rdc(ADDR_TOP_PENDING, 8'h00);
        u_host.wr(ADDR_SYS_MASK, 8'h02);
        pulse(0);
        rdc(ADDR_SYS_FLAGS, 8'h02);
        rdc(ADDR_TOP_PENDING, 8'h00);
        u_host.wr(ADDR_SYS_MASK, 8'h00);
        rdc(ADDR_TOP_PENDING, 8'h08);
        u_host.wr(ADDR_SYS_FLAGS, 8'h02);
        cmask = 8'h7F;
        pulse(1);
        rdc(ADDR_CHARGER_FLAGS, 8'h40);
        rdc(ADDR_TOP_PENDING, 8'h00);
        cmask = 8'h00;
        u_host.wr(ADDR_CHARGER_FLAGS, 8'h40);
    endtask
    task automatic t_thresholds();
        logic [6:0] pat[4] = '{7'h00, 7'h7F, 7'h55, 7'h2A};
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            #1 thr = pat[k];
            repeat (2) @(posedge i_clk);
            chk({6'h0, o_heat_warn_threshold}, {6'h0, pat[k][1:0]});
            chk({5'h0, o_heat_shutdown_threshold}, {5'h0, pat[k][4:2]});
            chk({6'h0, o_supply_low_threshold}, {6'h0, pat[k][6:5]});
        end
    endtask
    task automatic t_pulses();
        int         pb[4] = '{1, 6, 4, 3};
        logic [7:0] a, e, t;
        for (int k = 0; k < 4; k++) begin
            a = (k == 0) ? ADDR_SYS_FLAGS : ADDR_CHARGER_FLAGS;
            t = (k == 0) ? 8'h08 : 8'h04;
            e = 8'h01 << pb[k];
            pulse(k);
            rdc(a, e);
            rdc(ADDR_TOP_PENDING, t);
            chk({7'h0, pin_lvl}, 8'h00);
            pulse(k);
            u_host.wr(a, ~e);
            rdc(a, e);
            u_host.wr(a, e);
            rdc(a, 8'h00);
            rdc(ADDR_TOP_PENDING, 8'h00);
            chk({7'h0, pin_lvl}, 8'h01);
        end
    endtask
    task automatic t_group();
        pulse(0);
        pulse(2);
        rdc(ADDR_TOP_PENDING, 8'h0C);
        u_host.wr(ADDR_SYS_FLAGS, 8'h02);
        pulse(1);
        rdc(ADDR_TOP_PENDING, 8'h04);
        chk({7'h0, pin_lvl}, 8'h00);
        u_host.wr(ADDR_CHARGER_FLAGS, 8'h10);
        rdc(ADDR_TOP_PENDING, 8'h04);
        u_host.wr(ADDR_CHARGER_FLAGS, 8'h40);
        rdc(ADDR_TOP_PENDING, 8'h00);
        // event and clear land on one edge: the set must win
        fork
            pulse(0);
            u_host.wr(ADDR_SYS_FLAGS, 8'h02);
        join
        rdc(ADDR_SYS_FLAGS, 8'h02);
        u_host.wr(ADDR_SYS_FLAGS, 8'h02);
    endtask
    task automatic t_levels();
        int         lb[8] = '{4, 3, 2, 0, 5, 2, 1, 0};
        logic [7:0] a, e;
        for (int k = 0; k < 8; k++) begin
            a = (k < 4) ? ADDR_SYS_FLAGS : ADDR_CHARGER_FLAGS;
            e = 8'h01 << lb[k];
            @(posedge i_clk);
            #1 lv[k] = 1'b1;
            repeat (8) @(posedge i_clk);
            rdc(a, e);
            u_host.wr(a, e);
            @(posedge i_clk);
            #1 lv[k] = 1'b0;
            repeat (8) @(posedge i_clk);
            rdc(a, (k == 3 || k > 4) ? e : 8'h00);
            u_host.wr(a, e);
        end
    endtask
    task automatic t_on_key();
        @(posedge i_clk);
        #1 i_on_key_n = 1'b0;
        repeat (PUSH / 2) @(posedge i_clk);
        #1 i_on_key_n = 1'b1;
        repeat (8) @(posedge i_clk);
        rdc(ADDR_SYS_FLAGS, 8'h00);
        i_on_key_n = 1'b0;
        repeat (PUSH * 2) @(posedge i_clk);
        rdc(ADDR_SYS_FLAGS, 8'h20);
        i_on_key_n = 1'b1;
        u_host.wr(ADDR_SYS_FLAGS, 8'h20);
        rdc(ADDR_SYS_FLAGS, 8'h00);
    endtask

    initial begin
        do_reset();
        t_reset_vals();
        t_mask();
        t_thresholds();
        t_pulses();
        t_group();
        t_levels();
        t_on_key();
        pulse(0);
        do_reset();
        t_reset_vals();
        summarize();
    end
endmodule
